// File: design/epd_ctrl.sv
// Host-side controller for a 1M x 1 multiplexed-strobe dynamic memory with page access.
// Assumes the memory sits on plain pins; its data output arrives asynchronously.
// Writes use early write; refresh is strobe-only or hidden after a read.

// What this block does
// - Row half driven, latched at row strobe fall
// - Column half driven on same ten pins
// - Address stable before each capturing strobe falls
// - Same-row accesses cycle column strobe only
// - Reads and writes mix freely within page
// - Refresh all 512 rows every 8 ms
// - Strobe-only refresh: column high, own row
// - Hidden refresh: column low, row strobe cycles
// - Wait 200 us, then eight init cycles
module epd_ctrl #(
   parameter int INIT_WAIT = epd_pkg::INIT_CYC,
   parameter int PAGE_MAX = epd_pkg::PAGE_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // User request port
   input wire logic reqValid,
   input wire epd_pkg::epd_req_t req,
   output logic reqReady,
   // User read answer
   output logic rspValid,
   output logic rspData,
   // Memory pins
   output epd_pkg::epd_pins_t pins,
   input wire logic dataFromMem
);

   // ==========================================================
   // State
   localparam epd_pkg::epd_state_t RST_STATE = '{
      st: epd_pkg::ST_POWER,
      cnt: epd_pkg::CNT_W'(INIT_WAIT - 1),
      refTmr: epd_pkg::CNT_W'(epd_pkg::REF_INT_CYC - 1),
      pageTmr: '0,
      refRow: '0,
      initLeft: 4'(epd_pkg::INIT_CYCLES),
      refPend: 1'b0,
      haveReq: 1'b0,
      req: '0,
      openRow: '0,
      sync: '0,
      pins: '{rowStrobeN: 1'b1, colStrobeN: 1'b1, writeSelN: 1'b1, muxAddrPins: '0, dataToMem: 1'b0},
      reqReady: 1'b0,
      rspValid: 1'b0,
      rspData: 1'b0
   };

   epd_pkg::epd_state_t s_q;
   epd_pkg::epd_state_t s_d;
   logic accept;

   function automatic logic [epd_pkg::ROW_W-1:0] rowOf(input logic [epd_pkg::ADDR_W-1:0] a);
      return a[epd_pkg::ADDR_W-1 -: epd_pkg::ROW_W];
   endfunction

   function automatic logic [epd_pkg::ROW_W-1:0] refAddr(input logic [epd_pkg::REF_ROW_W-1:0] r);
      return {1'b0, r};
   endfunction

   assign accept = reqValid && s_q.reqReady;

   // ==========================================================
   // Next-state logic
   always_comb begin
      s_d = s_q;
      s_d.rspValid = 1'b0;
      s_d.cnt = (s_q.cnt != '0) ? s_q.cnt - 1'b1 : '0;
      s_d.pageTmr = (s_q.pageTmr != '0) ? s_q.pageTmr - 1'b1 : '0;
      // First stage feeds only the second
      s_d.sync = {s_q.sync[epd_pkg::SYNC_STAGES-2:0], dataFromMem};
      // Row refresh pacing; a new tick wins over a clear below
      if (s_q.refTmr == '0) begin
         s_d.refTmr = epd_pkg::CNT_W'(epd_pkg::REF_INT_CYC - 1);
      end else begin
         s_d.refTmr = s_q.refTmr - 1'b1;
      end
      if (accept) begin
         s_d.req = req;
      end
      unique case (s_q.st)
         epd_pkg::ST_POWER: begin
            if (s_q.cnt == '0) begin
               s_d.st = epd_pkg::ST_IDLE;
            end
         end
         epd_pkg::ST_IDLE: begin
            if (s_q.refPend || s_q.initLeft != '0) begin
               s_d.pins.muxAddrPins = refAddr(s_q.refRow);
               s_d.haveReq = 1'b0;
               s_d.st = epd_pkg::ST_RAS;
            end else if (accept) begin
               s_d.pins.muxAddrPins = rowOf(req.addr);
               s_d.haveReq = 1'b1;
               s_d.st = epd_pkg::ST_RAS;
            end
         end
         epd_pkg::ST_RAS: begin
            // Address was set up a full cycle before this fall
            s_d.pins.rowStrobeN = 1'b0;
            s_d.pageTmr = epd_pkg::CNT_W'(PAGE_MAX - 1);
            s_d.openRow = s_q.pins.muxAddrPins;
            if (s_q.haveReq) begin
               s_d.cnt = epd_pkg::CNT_W'(epd_pkg::RAH_CYC - 1);
               s_d.st = epd_pkg::ST_COL;
            end else begin
               s_d.cnt = epd_pkg::CNT_W'(epd_pkg::RAS_CYC - 1);
               s_d.st = epd_pkg::ST_REF;
            end
         end
         epd_pkg::ST_COL: begin
            if (s_q.cnt == '0) begin
               // Column goes out before the strobe, so access overlaps it
               s_d.pins.muxAddrPins = s_q.req.addr[epd_pkg::COL_W-1:0];
               s_d.pins.writeSelN = ~s_q.req.write;
               s_d.pins.dataToMem = s_q.req.wdata;
               s_d.st = epd_pkg::ST_CASLO;
            end
         end
         epd_pkg::ST_CASLO: begin
            s_d.pins.colStrobeN = 1'b0;
            s_d.cnt = epd_pkg::CNT_W'((s_q.req.write ? epd_pkg::RAS_CYC : epd_pkg::RD_CYC) - 1);
            s_d.st = epd_pkg::ST_CAS;
         end
         epd_pkg::ST_CAS: begin
            // Read waits for access time plus the synchroniser, then a settled sample
            if (s_q.cnt == '0 && (s_q.req.write || s_q.sync[1] == s_q.sync[2])) begin
               s_d.haveReq = 1'b0;
               s_d.pins.writeSelN = 1'b1;
               if (!s_q.req.write) begin
                  s_d.rspValid = 1'b1;
                  s_d.rspData = s_q.sync[2];
               end
               if (!s_q.req.write && s_q.refPend) begin
                  // Keep data on the pin while the row strobe cycles
                  s_d.pins.rowStrobeN = 1'b1;
                  s_d.cnt = epd_pkg::CNT_W'(epd_pkg::RP_CYC - 1);
                  s_d.st = epd_pkg::ST_HID;
               end else begin
                  s_d.pins.colStrobeN = 1'b1;
                  s_d.st = epd_pkg::ST_OPEN;
               end
            end
         end
         epd_pkg::ST_OPEN: begin
            if (s_q.refPend || s_q.pageTmr == '0) begin
               s_d.pins.rowStrobeN = 1'b1;
               s_d.cnt = epd_pkg::CNT_W'(epd_pkg::RP_CYC - 1);
               s_d.st = epd_pkg::ST_PRE;
            end else if (accept) begin
               s_d.haveReq = 1'b1;
               if (rowOf(req.addr) == s_q.openRow) begin
                  s_d.cnt = '0;
                  s_d.st = epd_pkg::ST_COL;
               end else begin
                  s_d.pins.rowStrobeN = 1'b1;
                  s_d.cnt = epd_pkg::CNT_W'(epd_pkg::RP_CYC - 1);
                  s_d.st = epd_pkg::ST_PRE;
               end
            end
         end
         epd_pkg::ST_PRE: begin
            if (s_q.cnt == '0) begin
               // A held request goes first so it is never dropped; refresh follows its access
               if (s_q.haveReq) begin
                  s_d.pins.muxAddrPins = rowOf(s_q.req.addr);
                  s_d.st = epd_pkg::ST_RAS;
               end else if (s_q.refPend || s_q.initLeft != '0) begin
                  s_d.pins.muxAddrPins = refAddr(s_q.refRow);
                  s_d.st = epd_pkg::ST_RAS;
               end else begin
                  s_d.st = epd_pkg::ST_IDLE;
               end
            end
         end
         epd_pkg::ST_REF: begin
            if (s_q.cnt == '0) begin
               s_d.pins.rowStrobeN = 1'b1;
               s_d.pins.colStrobeN = 1'b1;
               s_d.cnt = epd_pkg::CNT_W'(epd_pkg::RP_CYC - 1);
               s_d.refRow = s_q.refRow + 1'b1;
               s_d.initLeft = (s_q.initLeft != '0) ? s_q.initLeft - 1'b1 : '0;
               s_d.st = epd_pkg::ST_PRE;
            end
         end
         epd_pkg::ST_HID: begin
            if (s_q.cnt == '0) begin
               s_d.pins.muxAddrPins = refAddr(s_q.refRow);
               s_d.haveReq = 1'b0;
               s_d.st = epd_pkg::ST_RAS;
            end
         end
      endcase
      // A pacing tick in the same cycle as a finished refresh is kept
      if (s_q.st == epd_pkg::ST_REF && s_q.cnt == '0) begin
         s_d.refPend = (s_q.refTmr == '0);
      end else if (s_q.refTmr == '0) begin
         s_d.refPend = 1'b1;
      end
      // Ready only where a request can be taken next cycle without loss
      // Late page accesses are refused so the row-low limit still holds
      s_d.reqReady = (s_d.st == epd_pkg::ST_IDLE || s_d.st == epd_pkg::ST_OPEN) && !s_d.refPend &&
         !s_d.haveReq && s_d.initLeft == '0 &&
         (s_d.st == epd_pkg::ST_IDLE || s_d.pageTmr > epd_pkg::CNT_W'(2 * epd_pkg::RD_CYC));
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= RST_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reqReady = s_q.reqReady;
   assign rspValid = s_q.rspValid;
   assign rspData = s_q.rspData;
   assign pins = s_q.pins;

   // ==========================================================
   // Checks
   sequence sRowLowMin;
      !pins.rowStrobeN [*3];
   endsequence

   sequence sEarlyWriteSetup;
      !pins.writeSelN && pins.colStrobeN ##1 !pins.colStrobeN;
   endsequence

   a_row_addr_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(pins.rowStrobeN) |-> $stable(pins.muxAddrPins))
      else $error("row address changed at row strobe fall");

   a_col_addr_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(pins.colStrobeN) |-> $stable(pins.muxAddrPins) && !pins.rowStrobeN)
      else $error("column address not settled at column strobe fall");

   a_row_low_time: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(pins.rowStrobeN) |=> sRowLowMin)
      else $error("row strobe low too short");

   a_early_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(pins.colStrobeN) && !pins.writeSelN |-> !$past(pins.writeSelN) && $stable(pins.dataToMem))
      else $error("write select not low before column strobe");

   a_write_held: assert property (@(posedge core_clk) disable iff (!rst_n)
      sEarlyWriteSetup |-> !pins.writeSelN [*4])
      else $error("write select released too early");

   a_read_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rspValid) |-> !$past(pins.colStrobeN, 7) && !$past(pins.colStrobeN, 1))
      else $error("read answered before access time");

   a_ref_row_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(pins.rowStrobeN) && !s_q.haveReq |-> !pins.muxAddrPins[epd_pkg::ROW_W-1])
      else $error("refresh row outside nine-bit range");

   a_ras_only_ref: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(pins.rowStrobeN) && !s_q.haveReq && pins.colStrobeN |-> pins.colStrobeN [*4])
      else $error("column strobe moved during strobe-only refresh");

   a_hidden_ref: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(pins.rowStrobeN) && !pins.colStrobeN |-> !pins.colStrobeN [*8])
      else $error("column strobe released during hidden refresh");

   a_init_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
      reqReady |-> s_q.initLeft == '0 && s_q.st != epd_pkg::ST_POWER)
      else $error("request taken before initialisation finished");

   a_ref_due: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(s_q.refPend) && s_q.st != epd_pkg::ST_POWER |-> ##[1:40] (s_q.st == epd_pkg::ST_REF))
      else $error("refresh not started in time");

endmodule

// File: design/epd_pkg.sv
// Shared constants and carrier types for the page-mode dynamic memory controller.
// Assumes one 40 MHz core clock; all memory timing is expressed in whole cycles of it.
package epd_pkg;

   // ==========================================================
   // Clock and geometry
   localparam int CLK_NS = 25;
   localparam int ROW_W = 10;
   localparam int COL_W = 10;
   localparam int ADDR_W = ROW_W + COL_W;
   localparam int REF_ROW_W = 9;
   localparam int REF_ROWS = 512;
   localparam int SYNC_STAGES = 3;
   localparam int CNT_W = 14;
   localparam int INIT_CYCLES = 8;

   // ==========================================================
   // Memory timing in nanoseconds, as printed for the fastest grade
   localparam int T_RAS_NS = 80;
   localparam int T_RP_NS = 60;
   localparam int T_RAH_NS = 12;
   localparam int T_RAC_NS = 80;
   localparam int T_CAC_NS = 20;
   localparam int T_AA_NS = 40;
   localparam int T_RASP_NS = 100000;
   localparam int T_REF_NS = 8000000;
   localparam int T_INIT_NS = 200000;

   // Least times round up, longest times round down, never under one cycle
   function automatic int ceilCyc(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction

   function automatic int floorCyc(input int ns);
      return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
   endfunction

   function automatic int maxOf(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   // ==========================================================
   // Derived cycle counts
   localparam int RAS_CYC = ceilCyc(T_RAS_NS);
   localparam int RP_CYC = ceilCyc(T_RP_NS);
   localparam int RAH_CYC = ceilCyc(T_RAH_NS);
   localparam int ACC_CYC = ceilCyc(maxOf(T_RAC_NS, maxOf(T_CAC_NS, T_AA_NS)));
   localparam int RD_CYC = ACC_CYC + SYNC_STAGES;
   localparam int PAGE_CYC = floorCyc(T_RASP_NS);
   localparam int REF_INT_CYC = floorCyc(T_REF_NS / REF_ROWS);
   localparam int INIT_CYC = ceilCyc(T_INIT_NS);

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic rowStrobeN;
      logic colStrobeN;
      logic writeSelN;
      logic [ROW_W-1:0] muxAddrPins;
      logic dataToMem;
   } epd_pins_t;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic wdata;
   } epd_req_t;

   typedef enum logic [3:0] {
      ST_POWER, ST_IDLE, ST_RAS, ST_COL, ST_CASLO, ST_CAS, ST_OPEN, ST_PRE, ST_REF, ST_HID
   } epd_fsm_t;

   typedef struct packed {
      epd_fsm_t st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] refTmr;
      logic [CNT_W-1:0] pageTmr;
      logic [REF_ROW_W-1:0] refRow;
      logic [3:0] initLeft;
      logic refPend;
      logic haveReq;
      epd_req_t req;
      logic [ROW_W-1:0] openRow;
      logic [SYNC_STAGES-1:0] sync;
      epd_pins_t pins;
      logic reqReady;
      logic rspValid;
      logic rspData;
   } epd_state_t;

endpackage

// File: testbench/epd_mem_model.sv
// Behavioural 1M x 1 dynamic memory as seen at its strobe pins.
// Assumes every pin is driven from registers; no analogue or supply effects are modelled.
module epd_mem_model (
   // Pins from the controller, and access time in ns from the bench
   input wire epd_pkg::epd_pins_t pins,
   input wire logic [7:0] accNs,
   // Data output back to the controller
   output logic dataFromMem
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Cell array and latches
   logic mem [int];
   logic [9:0] rowQ = 10'h000;
   logic [9:0] colQ = 10'h000;
   logic outOn = 1'b0;
   logic qVal = 1'b0;
   int intRefs = 0;

   // Row fall with column high opens a row; with column low it refreshes from the internal counter
   always @(negedge pins.rowStrobeN) begin
      if (pins.colStrobeN) begin
         rowQ = pins.muxAddrPins;
      end else begin
         intRefs++;
      end
   end

   // Column latch; early write stores at once, a read waits out the access time
   always @(negedge pins.colStrobeN) begin
      colQ = pins.muxAddrPins;
      if (!pins.writeSelN) begin
         mem[{rowQ, colQ}] = pins.dataToMem;
      end else begin
         #(accNs);
         if (!pins.colStrobeN) begin
            qVal = mem.exists({rowQ, colQ}) ? mem[{rowQ, colQ}] : 1'b0;
            outOn = 1'b1;
         end
      end
   end

   // Column high floats the output again
   always @(posedge pins.colStrobeN) begin
      outOn = 1'b0;
   end

   // Delayed write strobes data with write select while the column is low
   always @(negedge pins.writeSelN) begin
      if (!pins.colStrobeN && !pins.rowStrobeN) begin
         mem[{rowQ, colQ}] = pins.dataToMem;
      end
   end

   // A floating output must not look like the last bit, so show its inverse
   assign dataFromMem = outOn ? qVal : ~qVal;
endmodule

// File: testbench/epd_ctrl_tb.sv
// Self-checking bench for the page-mode dynamic memory controller.
// Assumes the behavioural memory model on the pins and shortened init and page counts.
module epd_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Clock, reset and wiring
   localparam int INIT_W = 20;
   localparam int LIMIT = 20000;
   logic core_clk;
   logic rst_n;
   logic reqValid;
   epd_pkg::epd_req_t req;
   logic reqReady;
   logic rspValid;
   logic rspData;
   epd_pkg::epd_pins_t pins;
   logic dataFromMem;
   logic [7:0] accNs;
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   int rasFalls = 0;
   int colFalls = 0;
   int hidFalls = 0;
   int firstRas = -1;
   int relCyc;
   logic idleWin = 1'b0;
   logic [9:0] refQ [$];

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   epd_ctrl #(.INIT_WAIT(INIT_W), .PAGE_MAX(50)) epd_ctrl_i (.core_clk(core_clk), .rst_n(rst_n),
      .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .pins(pins), .dataFromMem(dataFromMem));
   epd_mem_model epd_mem_model_i (.pins(pins), .accNs(accNs), .dataFromMem(dataFromMem));

   // ==========================================================
   // Pin monitors and hang guard
   always @(negedge pins.rowStrobeN) begin
      if (rst_n) begin
         rasFalls++;
         if (!pins.colStrobeN) hidFalls++;
         if (firstRas < 0) firstRas = cyc;
         if (idleWin) refQ.push_back(pins.muxAddrPins);
      end
   end
   always @(negedge pins.colStrobeN) if (rst_n) colFalls++;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         num_errors++;
         wrap_up();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chkBit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chkNum(input string what, input int exp, input int got);
      compares++;
      if (got != exp) begin
         num_errors++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Request held from a falling edge until a rising edge sees ready
   task automatic send(input logic wr, input logic [19:0] addr, input logic wd);
      @(negedge core_clk);
      reqValid = 1'b1;
      req.write = wr;
      req.addr = addr;
      req.wdata = wd;
      while (reqReady !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      reqValid = 1'b0;
   endtask

   // Read with the wrong bit on the data pin, which the memory must ignore
   task automatic readChk(input logic [19:0] addr, input logic exp, input string what);
      int n;
      n = 0;
      send(1'b0, addr, ~exp);
      while (rspValid !== 1'b1 && n < 60) begin
         @(negedge core_clk);
         n++;
      end
      chkBit("read answered", 1'b1, rspValid);
      chkBit(what, exp, rspData);
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_init();
      while (reqReady !== 1'b1) @(negedge core_clk);
      chkBit("init cycles", 1'b1, rasFalls >= epd_pkg::INIT_CYCLES);
      chkBit("power wait", 1'b1, firstRas - relCyc >= INIT_W);
      chkNum("column falls in init", 0, colFalls);
   endtask

   // Mixed page traffic on one row, then both address extremes
   task automatic test_rw();
      int r0;
      r0 = rasFalls;
      send(1'b1, {10'h2AA, 10'h000}, 1'b1);
      readChk({10'h2AA, 10'h000}, 1'b1, "page read col 0");
      send(1'b1, {10'h2AA, 10'h001}, 1'b0);
      readChk({10'h2AA, 10'h001}, 1'b0, "page read col 1");
      chkBit("page kept open", 1'b1, rasFalls - r0 <= 3);
      send(1'b1, {10'h2AA, 10'h002}, 1'b0);
      send(1'b1, {10'h2AA, 10'h3FF}, 1'b1);
      send(1'b1, 20'hFFFFF, 1'b1);
      send(1'b1, 20'h00000, 1'b0);
      readChk(20'hFFFFF, 1'b1, "top cell");
      readChk(20'h00000, 1'b0, "bottom cell");
      readChk({10'h2AA, 10'h3FF}, 1'b1, "last column");
   endtask

   // Idle long enough for two refresh ticks; only strobe-only refreshes may appear
   task automatic test_idle_refresh();
      int c0;
      c0 = colFalls;
      refQ.delete();
      idleWin = 1'b1;
      repeat (2 * epd_pkg::REF_INT_CYC + 30) @(negedge core_clk);
      idleWin = 1'b0;
      chkBit("two refreshes", 1'b1, refQ.size() >= 2);
      chkNum("column idle in refresh", c0, colFalls);
      if (refQ.size() >= 2) begin
         chkBit("refresh row high bit", 1'b0, refQ[0][9]);
         chkNum("refresh row step", refQ[0] + 1, refQ[1]);
      end
      readChk(20'hFFFFF, 1'b1, "kept after refresh");
   endtask

   // Slow memory and back-to-back page reads across refresh ticks
   task automatic test_hidden();
      int h0;
      logic exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      h0 = hidFalls;
      accNs = 8'h3C;
      send(1'b1, {10'h2AA, 10'h003}, 1'b1);
      for (int i = 0; i < 200; i++) begin
         readChk({10'h2AA, 8'h00, i[1:0]}, exp[i % 4], "page read loop");
      end
      chkBit("hidden refresh seen", 1'b1, hidFalls > h0);
      accNs = 8'h14;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      reqValid = 1'b0;
      req = '0;
      accNs = 8'h14;
      repeat (5) @(negedge core_clk);
      chkBit("row strobe in reset", 1'b1, pins.rowStrobeN);
      chkBit("ready in reset", 1'b0, reqReady);
      relCyc = cyc;
      rst_n = 1'b1;
      test_init();
      test_rw();
      test_idle_refresh();
      test_hidden();
      wrap_up();
   end
endmodule
